// ---- logic/via_pkg.sv ----
// How it works
// - ten sources, one non-maskable, nine maskable
// - watchdog overflow in mode 1 raises NMI
// - watchdog interval overflow is maskable level 0
// - three edge pins at levels one to three
// - each pin selects rising, falling or both
// - uart receive and sio transfer share level 4
// - uart transmit done is level 5
// - 8-bit timer match is level 6
// - 16-bit timer match is level 7
// - conversion done is lowest level 8
// - smallest pending level is served first
// - per-source flag and mask, plus global enable
// - flag shows an NMI is in service
package via_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int unsigned VIA_NUM_MASKABLE = 9;     // maskable sources
	localparam int unsigned VIA_IDX_W        = 4;     // source index width
	localparam int unsigned VIA_VEC_W        = 16;    // vector address width
	localparam int unsigned VIA_ADDR_W       = 8;     // apb address width

	// ****************************************
	// source indices, index equals priority level
	// ****************************************
	localparam logic [3:0] VIA_SRC_WDT   = 4'h0;      // watchdog interval
	localparam logic [3:0] VIA_SRC_EXT0  = 4'h1;      // first edge pin
	localparam logic [3:0] VIA_SRC_SER   = 4'h4;      // uart rx or sio
	localparam logic [3:0] VIA_SRC_TX    = 4'h5;      // uart tx
	localparam logic [3:0] VIA_SRC_TMR8  = 4'h6;      // 8-bit timer
	localparam logic [3:0] VIA_SRC_TMR16 = 4'h7;      // 16-bit timer
	localparam logic [3:0] VIA_SRC_ADC   = 4'h8;      // a/d done

	// ****************************************
	// vector addresses
	// ****************************************
	localparam logic [15:0] VIA_VEC_NMI = 16'h0004;   // watchdog non-maskable
	localparam logic [15:0] VIA_VEC_TABLE [0:8] = '{
		16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C,
		16'h000E, 16'h0010, 16'h0012, 16'h0014};

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] VIA_OFF_CTRL  = 8'h00;     // enable, watchdog mode
	localparam logic [7:0] VIA_OFF_EDGE  = 8'h04;     // pin edge selects
	localparam logic [7:0] VIA_OFF_REQ   = 8'h08;     // request flags
	localparam logic [7:0] VIA_OFF_MASK  = 8'h0C;     // mask flags
	localparam logic [7:0] VIA_OFF_STATE = 8'h10;     // live state
	localparam logic [7:0] VIA_OFF_ISTAT = 8'h14;     // sticky events
	localparam logic [7:0] VIA_OFF_IMASK = 8'h18;     // event enables

	// ****************************************
	// reset values and bit positions
	// ****************************************
	localparam logic [8:0] VIA_RST_MASK  = 9'h1FF;    // all sources masked
	localparam logic [5:0] VIA_RST_EDGE  = 6'h00;     // no edge selected
	localparam logic [2:0] VIA_RST_IMASK = 3'h0;      // events gated off
	localparam int unsigned VIA_BIT_IE   = 0;         // ctrl global enable
	localparam int unsigned VIA_BIT_WDM  = 1;         // ctrl watchdog mode 1
	localparam int unsigned VIA_EV_NMI   = 0;         // nmi raised
	localparam int unsigned VIA_EV_ACK   = 1;         // vector accepted
	localparam int unsigned VIA_EV_OVR   = 2;         // request overrun

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0]
	{
		VIA_EDGE_NONE = 2'h0,
		VIA_EDGE_RISE = 2'h1,
		VIA_EDGE_FALL = 2'h2,
		VIA_EDGE_BOTH = 2'h3
	} via_edge_t;

	typedef enum logic [1:0]
	{
		VIA_ST_IDLE  = 2'b01,
		VIA_ST_OFFER = 2'b10
	} via_state_t;

	// one-cycle request pulses from on-chip peripherals
	typedef struct packed
	{
		logic watchdog_overflow_request;
		logic uart_rx_done_request;
		logic sio_xfer_done_request;
		logic uart_tx_done_request;
		logic timer8_match_request;
		logic timer16_match_request;
		logic adc_done_request;
	} via_periph_t;

	// offer to the cpu core
	typedef struct packed
	{
		logic        req;
		logic        nmi;
		logic [15:0] vector;
	} via_cpu_t;

	// vector lookup for a maskable source index
	function automatic logic [15:0] via_vector_of(input logic [3:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		if (idx <= VIA_SRC_ADC)
		begin
			v = VIA_VEC_TABLE[idx];
		end
		return v;
	endfunction : via_vector_of

endpackage : via_pkg

// ---- logic/via_edge_detect.sv ----
`timescale 1ns/100ps
module via_edge_detect
	import via_pkg::*;
(
	// clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// pin and selection
	input  wire logic      pin_async,
	input  via_pkg::via_edge_t edge_sel,
	// result
	output logic           edge_pulse
);
	import via_pkg::*;

	logic sync1_reg;    // first stage, read only by the second
	logic sync2_reg;    // second stage
	logic sync3_reg;    // third stage
	logic level_reg;    // accepted pin level

	// ****************************************
	// three-stage synchroniser, accepted level
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
			level_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= pin_async;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			// a change counts once stages two and three agree
			if (sync2_reg == sync3_reg)
			begin
				level_reg <= sync3_reg;
			end
		end
	end

	// ****************************************
	// edge qualification by selection
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			edge_pulse <= 1'b0;
		end
		else
		begin
			edge_pulse <= (sync2_reg == sync3_reg) && (sync3_reg != level_reg) &&
				((sync3_reg && edge_sel[0]) || (!sync3_reg && edge_sel[1]));
		end
	end

endmodule : via_edge_detect

// ---- logic/via_prio_pick.sv ----
`timescale 1ns/100ps
module via_prio_pick
	import via_pkg::*;
#(
	parameter int unsigned N = 9
)
(
	// eligible sources, bit 0 highest
	input  wire logic [N-1:0] elig,
	// winner
	output logic              any,
	output logic [3:0]        idx
);
	import via_pkg::*;

	// ****************************************
	// fixed priority, lowest index wins
	// ****************************************
	always_comb
	begin
		any = 1'b0;
		idx = 4'h0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (elig[i])
			begin
				any = 1'b1;
				idx = 4'(i);
			end
		end
	end

endmodule : via_prio_pick

// ---- logic/via_arbiter.sv ----
`timescale 1ns/100ps
module via_arbiter
	import via_pkg::*;
(
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic [via_pkg::VIA_ADDR_W-1:0] paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	// request sources
	input  via_pkg::via_periph_t          periph_req,
	input  wire logic [2:0]               ext_edge_pin,
	// cpu core
	output via_pkg::via_cpu_t             cpu_offer,
	input  wire logic                     cpu_ack,
	input  wire logic                     cpu_nmi_return,
	// interrupt
	output logic                          irq
);
	import via_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic        ie_reg;          // global_request_enable
	logic        wdm_reg;         // watchdog mode 1 selected
	logic [5:0]  edge_sel_reg;    // two bits per pin
	logic [8:0]  req_flag_reg;    // maskable request flags
	logic [8:0]  request_mask_flag_reg; // one mask per source
	logic        nmi_pend_reg;    // non-maskable request pending
	logic        nmi_in_service_flag_reg; // nmi being serviced
	logic [2:0]  istat_reg;       // sticky events
	logic [2:0]  imask_reg;       // event enables
	logic [31:0] prdata_reg;      // captured read data
	via_state_t  state_reg;       // offer state
	logic        offer_nmi_reg;   // offer is the nmi
	logic [3:0]  src_reg;         // offered maskable index
	logic [15:0] vector_reg;      // offered vector
	logic [2:0]  ext_edge;        // qualified pin edges
	logic [8:0]  req_set;         // flag set terms
	logic [8:0]  req_clr;         // flag clear terms
	logic [8:0]  mask_elig;       // flags past mask and enable
	logic        nmi_raise;       // watchdog overflow, mode 1
	logic        nmi_elig;        // nmi may be offered
	logic        pick_any;        // some maskable eligible
	logic [3:0]  pick_idx;        // best maskable
	logic        ack_take;        // acknowledge accepted
	logic        withdraw;        // offered maskable lost eligibility or an nmi waits
	logic        wr_en;           // apb write strobe
	logic        rd_setup;        // apb read setup
	logic        mapped;          // address decodes
	logic [31:0] rd_next;         // read mux
	logic [2:0]  ev_set;          // event set terms

	// ****************************************
	// pin edge detectors
	// ****************************************
	for (genvar g = 0; g < 3; g++)
	begin : g_ext
		via_edge_detect u_edge
		(
			.pclk       (pclk),
			.presetn    (presetn),
			.pin_async  (ext_edge_pin[g]),
			.edge_sel   (via_edge_t'(edge_sel_reg[2*g +: 2])),
			.edge_pulse (ext_edge[g])
		);
	end

	// ****************************************
	// request sources to flag set terms
	// ****************************************
	always_comb
	begin
		req_set = 9'h000;
		nmi_raise = periph_req.watchdog_overflow_request && wdm_reg;
		req_set[VIA_SRC_WDT] = periph_req.watchdog_overflow_request && !wdm_reg;
		req_set[VIA_SRC_EXT0 +: 3] = ext_edge;
		req_set[VIA_SRC_SER] = periph_req.uart_rx_done_request ||
			periph_req.sio_xfer_done_request;
		req_set[VIA_SRC_TX] = periph_req.uart_tx_done_request;
		req_set[VIA_SRC_TMR8] = periph_req.timer8_match_request;
		req_set[VIA_SRC_TMR16] = periph_req.timer16_match_request;
		req_set[VIA_SRC_ADC] = periph_req.adc_done_request;
	end

	// ****************************************
	// apb strobes and clear terms
	// ****************************************
	assign wr_en    = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign ack_take = (state_reg == VIA_ST_OFFER) && cpu_ack;

	always_comb
	begin
		req_clr = 9'h000;
		// write one to clear
		if (wr_en && (paddr == VIA_OFF_REQ))
		begin
			req_clr = pwdata[8:0];
		end
		// acknowledged source drops its flag
		if (ack_take && !offer_nmi_reg)
		begin
			req_clr[src_reg] = 1'b1;
		end
	end

	// ****************************************
	// maskable request flags, set wins
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_flag_reg <= 9'h000;
		end
		else
		begin
			req_flag_reg <= (req_flag_reg & ~req_clr) | req_set;
		end
	end

	// ****************************************
	// non-maskable pending and in-service flags
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nmi_pend_reg            <= 1'b0;
			nmi_in_service_flag_reg <= 1'b0;
		end
		else
		begin
			// new overflow wins over the acknowledge clear
			if (nmi_raise)
			begin
				nmi_pend_reg <= 1'b1;
			end
			else if (ack_take && offer_nmi_reg)
			begin
				nmi_pend_reg <= 1'b0;
			end
			// set on acceptance, cleared by return
			if (ack_take && offer_nmi_reg)
			begin
				nmi_in_service_flag_reg <= 1'b1;
			end
			else if (cpu_nmi_return)
			begin
				nmi_in_service_flag_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// eligibility and arbitration
	// ****************************************
	assign mask_elig = req_flag_reg & ~request_mask_flag_reg & {9{ie_reg}};
	assign nmi_elig  = nmi_pend_reg && !nmi_in_service_flag_reg;

	via_prio_pick #(.N(VIA_NUM_MASKABLE)) u_pick
	(
		.elig (mask_elig),
		.any  (pick_any),
		.idx  (pick_idx)
	);

	// offered maskable is dropped if it loses eligibility or an nmi waits
	assign withdraw = !offer_nmi_reg && (!mask_elig[src_reg] || nmi_elig);

	// ****************************************
	// offer state machine
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= VIA_ST_IDLE;
		end
		else
		begin
			unique case (state_reg)
				VIA_ST_IDLE:
				begin
					// nmi ignores enable and masks
					if (nmi_elig || pick_any)
					begin
						state_reg <= VIA_ST_OFFER;
					end
				end
				VIA_ST_OFFER:
				begin
					// one idle cycle lets flags settle before the next offer
					if (ack_take || withdraw)
					begin
						state_reg <= VIA_ST_IDLE;
					end
				end
				default:
				begin
					state_reg <= VIA_ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// offer latch, loaded while idle
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			offer_nmi_reg <= 1'b0;
			src_reg       <= 4'h0;
			vector_reg    <= 16'h0000;
		end
		else if (state_reg == VIA_ST_IDLE)
		begin
			offer_nmi_reg <= nmi_elig;
			src_reg       <= pick_idx;
			// watchdog interval reuses the nmi vector through the table
			vector_reg    <= nmi_elig ? VIA_VEC_NMI : via_vector_of(pick_idx);
		end
	end

	assign cpu_offer.req    = (state_reg == VIA_ST_OFFER);
	assign cpu_offer.nmi    = offer_nmi_reg;
	assign cpu_offer.vector = vector_reg;

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ie_reg                <= 1'b0;
			wdm_reg               <= 1'b0;
			edge_sel_reg          <= VIA_RST_EDGE;
			request_mask_flag_reg <= VIA_RST_MASK;
			imask_reg             <= VIA_RST_IMASK;
		end
		else if (wr_en)
		begin
			unique case (paddr)
				VIA_OFF_CTRL:
				begin
					ie_reg  <= pwdata[VIA_BIT_IE];
					wdm_reg <= pwdata[VIA_BIT_WDM];
				end
				VIA_OFF_EDGE:
				begin
					edge_sel_reg <= pwdata[5:0];
				end
				VIA_OFF_MASK:
				begin
					request_mask_flag_reg <= pwdata[8:0];
				end
				VIA_OFF_IMASK:
				begin
					imask_reg <= pwdata[2:0];
				end
				default:
				begin
					ie_reg <= ie_reg;
				end
			endcase
		end
	end

	// ****************************************
	// sticky events, set wins over write-one clear
	// ****************************************
	always_comb
	begin
		ev_set              = 3'h0;
		ev_set[VIA_EV_NMI]  = nmi_raise;
		ev_set[VIA_EV_ACK]  = ack_take;
		ev_set[VIA_EV_OVR]  = |(req_set & req_flag_reg & ~req_clr);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			istat_reg <= 3'h0;
		end
		else if (wr_en && (paddr == VIA_OFF_ISTAT))
		begin
			istat_reg <= (istat_reg & ~pwdata[2:0]) | ev_set;
		end
		else
		begin
			istat_reg <= istat_reg | ev_set;
		end
	end

	assign irq = |(istat_reg & imask_reg);

	// ****************************************
	// read mux and apb answer
	// ****************************************
	always_comb
	begin
		rd_next = 32'h0000_0000;
		mapped  = 1'b1;
		case (paddr)
			VIA_OFF_CTRL:  rd_next[1:0] = {wdm_reg, ie_reg};
			VIA_OFF_EDGE:  rd_next[5:0] = edge_sel_reg;
			VIA_OFF_REQ:   rd_next[9:0] = {nmi_pend_reg, req_flag_reg};
			VIA_OFF_MASK:  rd_next[8:0] = request_mask_flag_reg;
			VIA_OFF_STATE: rd_next = {vector_reg, 9'h000, src_reg, offer_nmi_reg,
				cpu_offer.req, nmi_in_service_flag_reg};
			VIA_OFF_ISTAT: rd_next[2:0] = istat_reg;
			VIA_OFF_IMASK: rd_next[2:0] = imask_reg;
			default:       mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= 32'h0000_0000;
		end
		else if (rd_setup)
		begin
			prdata_reg <= rd_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [8:0] below_src;        // sources outranking the offer
	always_comb
	begin
		for (int i = 0; i < 9; i++)
		begin
			below_src[i] = (4'(i) < src_reg);
		end
	end

	a_nmi_vector: assert property (
		cpu_offer.req && cpu_offer.nmi |-> cpu_offer.vector == VIA_VEC_NMI)
		else $error("nmi offered with wrong vector");
	a_nmi_raise: assert property (
		periph_req.watchdog_overflow_request && wdm_reg && !nmi_in_service_flag_reg
		|=> nmi_pend_reg ##1 (cpu_offer.req || $past(cpu_offer.req)))
		else $error("watchdog mode 1 overflow not raised as nmi");
	a_wdt_interval: assert property (
		periph_req.watchdog_overflow_request && !wdm_reg |=> req_flag_reg[0] && !nmi_pend_reg
		|| $past(nmi_pend_reg))
		else $error("interval overflow not flagged at level 0");
	a_serial_share: assert property (
		periph_req.uart_rx_done_request || periph_req.sio_xfer_done_request
		|=> req_flag_reg[VIA_SRC_SER])
		else $error("serial completion not flagged at level 4");
	a_prio_order: assert property (
		$rose(cpu_offer.req) && !cpu_offer.nmi |-> ($past(mask_elig) & below_src) == 9'h000)
		else $error("lower level offered over higher pending one");
	a_gate_enable: assert property (
		$rose(cpu_offer.req) && !cpu_offer.nmi
		|-> $past(ie_reg) && (($past(request_mask_flag_reg) & (9'h001 << src_reg)) == 9'h000))
		else $error("maskable offered while disabled or masked");
	a_vec_map: assert property (
		cpu_offer.req && !cpu_offer.nmi |-> cpu_offer.vector == VIA_VEC_TABLE[src_reg])
		else $error("maskable vector does not match its source");
	a_ack_clear: assert property (
		ack_take && !offer_nmi_reg && !req_set[src_reg]
		|=> !req_flag_reg[$past(src_reg)] && !cpu_offer.req)
		else $error("acknowledged flag not cleared");
	a_flag_hold: assert property (
		req_flag_reg[VIA_SRC_ADC] && !ack_take && !(wr_en && paddr == VIA_OFF_REQ)
		|=> req_flag_reg[VIA_SRC_ADC])
		else $error("request flag dropped without acknowledge");
	a_nmi_in_service_flag_set: assert property (
		ack_take && offer_nmi_reg |=> nmi_in_service_flag_reg [*2] or
		(nmi_in_service_flag_reg ##1 $past(cpu_nmi_return)))
		else $error("in-service flag not set on nmi acceptance");

	c_nmi_taken:  cover property (ack_take && offer_nmi_reg);
	c_mask_taken: cover property (ack_take && !offer_nmi_reg && src_reg == VIA_SRC_ADC);
	c_two_pend:   cover property ($countones(mask_elig) >= 2 && state_reg == VIA_ST_IDLE);
	c_ext_edge:   cover property (ext_edge[2] ##[1:4] cpu_offer.req);

endmodule : via_arbiter

// ---- dv/via_cpu_model.sv ----
`timescale 1ns/100ps
// ****************************************
// cpu core stand-in
// ****************************************
module via_cpu_model
	import via_pkg::*;
(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// offer from the arbiter
	input  via_pkg::via_cpu_t cpu_offer,
	output logic              cpu_ack,
	output logic              cpu_nmi_return
);
	logic [1:0] wait_reg;  // pause before taking an offer
	logic [4:0] ret_reg;   // nmi handler cycles left

	// take an offer after a random pause, one-cycle ack pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cpu_ack  <= 1'b0;
			wait_reg <= 2'h0;
		end
		else if (cpu_ack)
		begin
			cpu_ack  <= 1'b0;
			wait_reg <= 2'($urandom_range(3, 0));
		end
		else if (cpu_offer.req && wait_reg == 2'h0)
			cpu_ack <= 1'b1;
		else if (cpu_offer.req)
			wait_reg <= wait_reg - 2'h1;
	end

	// nmi handler returns a fixed time after it was entered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ret_reg        <= 5'h00;
			cpu_nmi_return <= 1'b0;
		end
		else
		begin
			cpu_nmi_return <= (ret_reg == 5'h01);
			if (cpu_ack && cpu_offer.req && cpu_offer.nmi)
				ret_reg <= 5'h1E;
			else if (ret_reg != 5'h00)
				ret_reg <= ret_reg - 5'h01;
		end
	end
endmodule : via_cpu_model

// ---- dv/tb_vectored_interrupt_arbiter.sv ----
`timescale 1ns/100ps
module tb_vectored_interrupt_arbiter;
	import via_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        pclk         = 1'b0;
	logic        presetn      = 1'b0;
	logic [7:0]  paddr        = 8'h00;
	logic        psel         = 1'b0;
	logic        penable      = 1'b0;
	logic        pwrite       = 1'b0;
	logic [31:0] pwdata       = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	via_periph_t periph_req   = '0;
	logic [2:0]  ext_edge_pin = 3'h0;
	via_cpu_t    cpu_offer;
	logic        cpu_ack;
	logic        cpu_nmi_return;
	logic        irq;
	int          err_count    = 0;
	int          checked      = 0;
	logic [16:0] got_q [$];    // vectors taken by the core
	logic [16:0] exp_q [$];    // vectors expected
	logic [31:0] rd;           // last read data
	logic        rerr;         // last slave error
	logic        ie;           // random global enable
	logic [8:0]  msk;          // random masks
	logic [8:0]  lv;           // flags raised, by level
	logic [6:0]  p;            // random pulse set

	always #12.5 pclk = ~pclk;

	via_arbiter dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .periph_req(periph_req),
		.ext_edge_pin(ext_edge_pin), .cpu_offer(cpu_offer), .cpu_ack(cpu_ack),
		.cpu_nmi_return(cpu_nmi_return), .irq(irq));

	via_cpu_model core (.pclk(pclk), .presetn(presetn), .cpu_offer(cpu_offer),
		.cpu_ack(cpu_ack), .cpu_nmi_return(cpu_nmi_return));

	// log every vector the core takes
	always @(posedge pclk)
		if (cpu_offer.req === 1'b1 && cpu_ack === 1'b1)
			got_q.push_back({cpu_offer.nmi, cpu_offer.vector});

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] vec_of(input int lvl);
		return 16'h0004 + 16'(2 * lvl);
	endfunction : vec_of

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, waits for pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		// ends when pready is high, else the hang guard ends it
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pulse(input logic [6:0] v);
		@(posedge pclk);
		periph_req <= via_periph_t'(v);
		@(posedge pclk);
		periph_req <= '0;
	endtask : pulse

	// compare taken vectors against expected, then forget both
	task automatic served();
		chk(32'(got_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i])
			if (i < got_q.size())
				chk(32'(got_q[i]), 32'(exp_q[i]));
		got_q.delete();
		exp_q.delete();
	endtask : served

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	// hang guard
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_count++;
		complete_run();
	end

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		void'($urandom(8970));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, unmapped offset
		apb(VIA_OFF_MASK, 1'b0, 32'h0);
		chk(rd, 32'h1FF);
		apb(VIA_OFF_EDGE, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(32'(irq), 32'h0);
		apb(8'h1C, 1'b0, 32'h0);
		chk(32'(rerr), 32'h1);
		// random mixes of simultaneous requests
		repeat (24)
		begin
			ie = ($urandom_range(3, 0) != 0);
			msk = 9'($urandom) & 9'($urandom);
			p = 7'($urandom);
			apb(VIA_OFF_CTRL, 1'b1, 32'(ie));
			apb(VIA_OFF_MASK, 1'b1, 32'(msk));
			lv = {p[0], p[1], p[2], p[3], p[5] | p[4], 3'h0, p[6]};
			pulse(p);
			repeat (60) @(posedge pclk);
			for (int i = 0; i < 9; i++)
				if (ie && lv[i] && !msk[i])
					exp_q.push_back({1'b0, vec_of(i)});
			served();
			apb(VIA_OFF_REQ, 1'b0, 32'h0);
			chk(32'(rd[8:0]), 32'(ie ? lv & msk : lv));
			apb(VIA_OFF_REQ, 1'b1, 32'h1FF);
		end
		// every edge mode on every pin
		apb(VIA_OFF_CTRL, 1'b1, 32'h0);
		for (int pin = 0; pin < 3; pin++)
			for (int m = 0; m < 4; m++)
			begin
				apb(VIA_OFF_EDGE, 1'b1, 32'(m << (2 * pin)));
				for (int l = 1; l >= 0; l--)
				begin
					ext_edge_pin[pin] <= l[0];
					repeat (10) @(posedge pclk);
					apb(VIA_OFF_REQ, 1'b0, 32'h0);
					chk(32'(rd[8:0]), 32'((l ? m & 1 : m >> 1) << (pin + 1)));
					apb(VIA_OFF_REQ, 1'b1, 32'h1FF);
				end
			end
		// three pins at once, served in level order
		apb(VIA_OFF_EDGE, 1'b1, 32'h15);
		apb(VIA_OFF_MASK, 1'b1, 32'h0);
		apb(VIA_OFF_CTRL, 1'b1, 32'h1);
		ext_edge_pin <= 3'h7;
		repeat (40) @(posedge pclk);
		for (int i = 1; i < 4; i++)
			exp_q.push_back({1'b0, vec_of(i)});
		served();
		// non-maskable watchdog, in-service blocking, events
		apb(VIA_OFF_CTRL, 1'b1, 32'h2);
		apb(VIA_OFF_IMASK, 1'b1, 32'h1);
		pulse(7'h40);
		repeat (6) @(posedge pclk);
		apb(VIA_OFF_STATE, 1'b0, 32'h0);
		chk(32'(rd[0]), 32'h1);
		chk(32'(irq), 32'h1);
		pulse(7'h40);
		repeat (4) @(posedge pclk);
		chk(32'(got_q.size()), 32'h1);
		repeat (40) @(posedge pclk);
		exp_q.push_back({1'b1, VIA_VEC_NMI});
		exp_q.push_back({1'b1, 16'h0004});
		served();
		apb(VIA_OFF_IMASK, 1'b1, 32'h0);
		apb(VIA_OFF_ISTAT, 1'b0, 32'h0);
		chk(32'(rd[1:0]), 32'h3);
		chk(32'(irq), 32'h0);
		apb(VIA_OFF_ISTAT, 1'b1, 32'h7);
		apb(VIA_OFF_ISTAT, 1'b0, 32'h0);
		chk(rd, 32'h0);
		complete_run();
	end
endmodule : tb_vectored_interrupt_arbiter
